// ---- logic/iqo_map.svh ----
// constants for the incremental quadrature output stage
`ifndef IQO_MAP_SVH
`define IQO_MAP_SVH
// clock rate in kHz
`define IQO_CLK_KHZ 10000
// least fault flag low time in ms
`define IQO_FAULT_MIN_MS 20
// cycles for the least fault low time (rounded up)
`define IQO_FAULT_CYC ((`IQO_FAULT_MIN_MS * `IQO_CLK_KHZ + 0) / 1)
// counts per commutation revolution
`define IQO_COMM_STEPS 24'h00_0168
// commutation segment lengths and fold points in steps
`define IQO_SEG90 24'h00_005a
`define IQO_SEG120 24'h00_0078
`define IQO_SEG180 24'h00_00b4
`define IQO_SEG240 24'h00_00f0
`define IQO_SEG270 24'h00_010e
// phase codes of the quadrature cycle
`define IQO_PH_00 2'h0
`define IQO_PH_10 2'h1
`define IQO_PH_11 2'h2
`define IQO_PH_01 2'h3
`endif

// ---- logic/iqo_pkg.sv ----
// types for the incremental quadrature output stage
`default_nettype none
package iqo_pkg;
   // commutation pulse width options
   typedef enum logic [1:0] {
      IQO_COMM_2X180 = 2'h0,
      IQO_COMM_3X120 = 2'h1,
      IQO_COMM_4X90 = 2'h2
   } iqo_comm_t;
endpackage
`default_nettype wire

// ---- logic/iqo_sync.sv ----
// two flip-flop synchroniser for one pin level
`timescale 1ns/10ps
`default_nettype none
module iqo_sync (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta_q;
   logic q_q;
   // first stage feeds only the second
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         meta_q <= 1'b0;
         q_q <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_q <= meta_q;
      end
   end
   assign q_o = q_q;
endmodule
`default_nettype wire

// ---- logic/iqo_top.sv ----
// quadrature, reference, fault and commutation output generator
`timescale 1ns/10ps
`default_nettype none
`include "iqo_map.svh"
module iqo_top #(
   parameter logic [31:0] FAULT_CYC = `IQO_FAULT_CYC
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic step_i,
   input wire logic dir_i,
   input wire logic ref_mark_i,
   input wire logic malfunction_i,
   input wire logic single_ended_variant,
   input wire logic [1:0] comm_mode_i,
   output logic track_a_out,
   output logic track_b_out,
   output logic ref_pulse_out,
   output logic track_a_out_n,
   output logic track_b_out_n,
   output logic ref_pulse_out_n,
   output logic fault_flag_n,
   output logic [2:0] comm_o,
   output logic [2:0] comm_n_o
);
   // ==========================================================
   // input synchronisers
   logic step_s;
   logic malf_s;
   logic refm_s;
   iqo_sync u_sync_step (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .d_i(step_i),
      .q_o(step_s)
   );
   iqo_sync u_sync_malf (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .d_i(malfunction_i),
      .q_o(malf_s)
   );
   iqo_sync u_sync_refm (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .d_i(ref_mark_i),
      .q_o(refm_s)
   );
   // straps are pins as well; the two mode bits may settle a cycle
   // apart, so change the width option only while standing still
   logic var_s;
   wire [1:0] mode_s;
   iqo_sync u_sync_var (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .d_i(single_ended_variant),
      .q_o(var_s)
   );
   iqo_sync u_sync_mode0 (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .d_i(comm_mode_i[0]),
      .q_o(mode_s[0])
   );
   iqo_sync u_sync_mode1 (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .d_i(comm_mode_i[1]),
      .q_o(mode_s[1])
   );
   // ==========================================================
   // quadrature phase sequencer
   logic step_d1_q;
   logic [1:0] ph_q;
   logic [1:0] ph_d;
   logic [23:0] pos_q;
   logic [23:0] pos_d;
   wire step_edge = step_s & ~step_d1_q;
   assign ph_d = step_edge ? (dir_i ? ph_q - 2'h1 : ph_q + 2'h1) : ph_q;
   // mechanical position wraps once per revolution
   wire pos_top = (pos_q == `IQO_COMM_STEPS - 24'h00_0001);
   wire [23:0] pos_inc = pos_top ? 24'h00_0000 : pos_q + 24'h00_0001;
   wire [23:0] pos_dec = (pos_q == 24'h00_0000) ?
      `IQO_COMM_STEPS - 24'h00_0001 : pos_q - 24'h00_0001;
   assign pos_d = step_edge ? (dir_i ? pos_dec : pos_inc) : pos_q;
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         step_d1_q <= 1'b0;
         ph_q <= `IQO_PH_00;
         pos_q <= 24'h00_0000;
      end else begin
         step_d1_q <= step_s;
         ph_q <= ph_d;
         pos_q <= pos_d;
      end
   end
   // gray order 00,10,11,01 puts b a quarter behind a
   wire a_w = (ph_q == `IQO_PH_10) | (ph_q == `IQO_PH_11);
   wire b_w = (ph_q == `IQO_PH_11) | (ph_q == `IQO_PH_01);
   // reference only while both tracks high, a quarter period
   wire r_w = refm_s & (ph_q == `IQO_PH_11);
   // ==========================================================
   // fault flag stretcher
   logic [31:0] fcnt_q;
   logic [31:0] fcnt_d;
   // low held while faulty and for the least time after
   assign fcnt_d = malf_s ? FAULT_CYC :
      (fcnt_q != 32'h0000_0000) ? fcnt_q - 32'h0000_0001 : fcnt_q;
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         fcnt_q <= 32'h0000_0000;
      end else begin
         fcnt_q <= fcnt_d;
      end
   end
   wire fault_w = malf_s | (fcnt_q != 32'h0000_0000);
   // ==========================================================
   // commutation tracks
   // position folded into its segment by compare and subtract;
   // cheaper than a divider, since pos_q never leaves one turn
   wire [23:0] p180 = (pos_q >= `IQO_SEG180) ? pos_q - `IQO_SEG180 : pos_q;
   // three segments need two fold points
   wire [23:0] p120 = (pos_q >= `IQO_SEG240) ? pos_q - `IQO_SEG240 :
      (pos_q >= `IQO_SEG120) ? pos_q - `IQO_SEG120 : pos_q;
   // four segments need three fold points
   wire [23:0] p90 = (pos_q >= `IQO_SEG270) ? pos_q - `IQO_SEG270 :
      (pos_q >= `IQO_SEG180) ? pos_q - `IQO_SEG180 :
      (pos_q >= `IQO_SEG90) ? pos_q - `IQO_SEG90 : pos_q;
   // two segments of 180, tracks 60 apart, each high 90
   wire u180 = p180 < 24'h00_005a;
   wire v180 = (p180 >= 24'h00_003c) & (p180 < 24'h00_0096);
   wire w180 = (p180 >= 24'h00_0078) | (p180 < 24'h00_001e);
   // three segments of 120, tracks 40 apart, each high 60
   wire u120 = p120 < 24'h00_003c;
   wire v120 = (p120 >= 24'h00_0028) & (p120 < 24'h00_0064);
   wire w120 = (p120 >= 24'h00_0050) | (p120 < 24'h00_0014);
   // four segments of 90, tracks 30 apart, each high 45
   wire u90 = p90 < 24'h00_002d;
   wire v90 = (p90 >= 24'h00_001e) & (p90 < 24'h00_004b);
   wire w90 = (p90 >= 24'h00_003c) | (p90 < 24'h00_000f);
   // width option decode from the synchronised strap
   wire sel180 = (mode_s == iqo_pkg::IQO_COMM_2X180);
   wire sel120 = (mode_s == iqo_pkg::IQO_COMM_3X120);
   wire sel90 = (mode_s == iqo_pkg::IQO_COMM_4X90);
   // tracks gathered as w, v, u
   wire [2:0] set180 = {w180, v180, u180};
   wire [2:0] set120 = {w120, v120, u120};
   wire [2:0] set90 = {w90, v90, u90};
   // the spare code parks every track low
   wire [2:0] comm_w = sel180 ? set180 :
      sel120 ? set120 :
      sel90 ? set90 : 3'h0;
   // ==========================================================
   // output registers
   // one register stage for every output, so all pairs and all
   // tracks leave the block on the same edge with no skew
   wire keep_cmp = ~var_s;
   // quadrature and reference complements forced low in the reduced variant
   wire an_w = ~a_w & keep_cmp;
   wire bn_w = ~b_w & keep_cmp;
   wire rn_w = ~r_w & keep_cmp;
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         track_a_out <= 1'b0;
         track_b_out <= 1'b0;
         ref_pulse_out <= 1'b0;
      end else begin
         track_a_out <= a_w;
         track_b_out <= b_w;
         ref_pulse_out <= r_w;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         track_a_out_n <= 1'b0;
         track_b_out_n <= 1'b0;
         ref_pulse_out_n <= 1'b0;
      end else begin
         track_a_out_n <= an_w;
         track_b_out_n <= bn_w;
         ref_pulse_out_n <= rn_w;
      end
   end
   // flag high only in proper operation, low during reset
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         fault_flag_n <= 1'b0;
      end else begin
         fault_flag_n <= ~fault_w;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         comm_o <= 3'h0;
         comm_n_o <= 3'h0;
      end else begin
         comm_o <= comm_w;
         comm_n_o <= ~comm_w;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/iqo_counter.sv ----
// partner: counting electronics at the far end
`timescale 1ns/10ps
`default_nettype none
module iqo_counter (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic a_i,
   input wire logic b_i,
   output logic signed [15:0] pos_o
);
   logic [2:0] a_q, b_q;
   // sync, count by lead, skip double steps
   always_ff @(posedge clk_i) begin
      a_q <= {a_q[1:0], a_i};
      b_q <= {b_q[1:0], b_i};
      if (!nrst_i)
         pos_o <= '0;
      else if (a_q[2] ^ a_q[1] ^ b_q[2] ^ b_q[1])
         pos_o <= pos_o + (a_q[1] ^ b_q[2] ? 16'sh1 : -16'sh1);
   end
endmodule
`default_nettype wire

// ---- testbench/iqo_monitor.sv ----
// port checker for the quadrature output stage
`timescale 1ns/10ps
`default_nettype none
module iqo_monitor #(
   parameter logic [31:0] FAULT_CYC = 32'h0003_0d40
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic single_ended_variant,
   input wire logic track_a_out,
   input wire logic track_b_out,
   input wire logic ref_pulse_out,
   input wire logic track_a_out_n,
   input wire logic track_b_out_n,
   input wire logic ref_pulse_out_n,
   input wire logic fault_flag_n,
   input wire logic [2:0] comm_o,
   input wire logic [2:0] comm_n_o
);
   logic [31:0] low_q;
   logic [2:0] trk, cmp;
   // =====================================
   // helpers: a reset counts as a long low
   assign trk = {track_a_out, track_b_out, ref_pulse_out};
   assign cmp = {track_a_out_n, track_b_out_n, ref_pulse_out_n};
   always_ff @(posedge ref_clk_i)
      low_q <= !nrst_i ? FAULT_CYC : fault_flag_n ? '0 : low_q + 32'h1;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // =====================================
   // properties
   chk_one_track: assert property (
      !($changed(track_a_out) && $changed(track_b_out))) else $error("a b");
   chk_ref_gate: assert property (
      ref_pulse_out |-> track_a_out && track_b_out) else $error("ref");
   // strap passes two sync stages and the output stage
   chk_comp_pair: assert property (
      !single_ended_variant [*4] |-> cmp == ~trk) else $error("compl");
   chk_fault_hold: assert property (
      $rose(fault_flag_n) |-> low_q >= FAULT_CYC) else $error("fault");
   // first edge after reset still shows the all-low reset levels
   chk_comm_comp: assert property (
      $past(nrst_i) |-> comm_n_o == ~comm_o) else $error("comm");
   cover property ($rose(ref_pulse_out));
   cover property ($fell(fault_flag_n));
   cover property ($rose(comm_o[2]));
endmodule
bind iqo_top iqo_monitor #(.FAULT_CYC(FAULT_CYC)) mon (
   .ref_clk_i(ref_clk_i),
   .nrst_i(nrst_i),
   .single_ended_variant(single_ended_variant),
   .track_a_out(track_a_out),
   .track_b_out(track_b_out),
   .ref_pulse_out(ref_pulse_out),
   .track_a_out_n(track_a_out_n),
   .track_b_out_n(track_b_out_n),
   .ref_pulse_out_n(ref_pulse_out_n),
   .fault_flag_n(fault_flag_n),
   .comm_o(comm_o),
   .comm_n_o(comm_n_o)
);
`default_nettype wire

// ---- testbench/testbench.sv ----
// bench for the quadrature output stage
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 0, rst_n = 0, stp = 0, dir = 0, mrk = 0, mal = 0, se = 0;
   logic [1:0] mode = 2'h0;
   logic [6:0] o;
   logic [2:0] cu, cn;
   logic signed [15:0] pos;
   logic c0, r0;
   int failures = 0, compares = 0, rises = 0, refs = 0;
   initial forever #50 clk = ~clk;
   iqo_top #(.FAULT_CYC(32'h14)) dut (.ref_clk_i(clk), .nrst_i(rst_n),
      .step_i(stp), .dir_i(dir), .ref_mark_i(mrk), .malfunction_i(mal),
      .single_ended_variant(se), .comm_mode_i(mode), .track_a_out(o[6]),
      .track_b_out(o[5]), .ref_pulse_out(o[4]), .track_a_out_n(o[3]),
      .track_b_out_n(o[2]), .ref_pulse_out_n(o[1]), .fault_flag_n(o[0]),
      .comm_o(cu), .comm_n_o(cn));
   iqo_counter cnt (.clk_i(clk), .nrst_i(rst_n), .a_i(o[6]), .b_i(o[5]),
      .pos_o(pos));
   // rising edges of the first commutation track and of the reference pulse
   always @(posedge clk) begin
      c0 <= cu[0];
      if (cu[0] === 1'b1 && c0 === 1'b0) rises++;
      r0 <= o[4];
      if (o[4] === 1'b1 && r0 === 1'b0) refs++;
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   // steps held three cycles high and low, well clear of merging
   task automatic step(int n);
      repeat (n) begin
         stp = 1;
         cyc(3);
         stp = 0;
         cyc(3);
      end
   endtask
   task automatic t_motion();
      mrk = 1;
      step(8);
      cyc(6);
      chk("pos", 32'h8, pos);
      dir = 1;
      cyc(4);
      step(12);
      cyc(6);
      chk("pos", 32'hffff_fffc, pos);
      chk("refs", 32'h5, refs);
      dir = 0;
      mrk = 0;
   endtask
   task automatic t_variant();
      se = 1;
      cyc(4);
      chk("compl", 32'h0, o[3:1]);
      se = 0;
      cyc(4);
      chk("compl", 32'h7, o[3:1]);
   endtask
   // one missed cycle before counting starts, hence n plus one
   task automatic t_fault();
      int n = 0;
      mal = 1;
      cyc(1);
      mal = 0;
      cyc(3);
      while (o[0] !== 1'b1 && n < 99) begin
         n++;
         cyc(1);
      end
      chk("low", 32'h1, n + 1 >= 20 && n < 30);
   endtask
   task automatic t_comm();
      for (int m = 0; m < 3; m++) begin
         mode = m[1:0];
         cyc(4);
         rises = 0;
         step(360);
         cyc(6);
         chk("rises", m + 2, rises);
      end
      // spare code parks every commutation track low
      mode = 2'h3;
      cyc(4);
      chk("comm off", 32'h0, cu);
   endtask
   task automatic finish_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      cyc(4);
      rst_n = 1;
      cyc(2);
      chk("idle", 32'hf, o);
      t_motion();
      t_variant();
      t_fault();
      t_comm();
      finish_test();
   end
   // watchdog far beyond the expected run
   initial begin
      #3_000_000;
      failures++;
      finish_test();
   end
endmodule
`default_nettype wire
